/* File: logic/wdtt_pkg.sv */
// Purpose: shared constants of the watchdog timeout timer
// Assumes: one system clock at 200 MHz, slow oscillator sampled as a level
// Notes:   register offsets are byte addresses on the plain register port
package wdtt_pkg;
	// register offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_BOOT_CFG  = 8'h01;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h02;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h03;
	localparam logic [7:0] OFS_COUNT     = 8'h04;
	// control register fields
	localparam int BIT_RUN      = 7;
	localparam int BIT_CLEAR    = 6;
	localparam int BIT_TOFLAG   = 5;
	localparam int BIT_IDLE_RUN = 4;
	localparam int BIT_CAUSE    = 3;
	localparam int PS_LSB       = 0;
	localparam int PS_W         = 3;
	// boot config field
	localparam int BEH_LSB = 4;
	localparam int BEH_W   = 4;
	localparam logic [3:0] BEH_GP_TIMER  = 4'hF;
	localparam logic [3:0] BEH_RST_STOP  = 4'h5;
	// irq status / mask fields
	localparam int IRQ_TIMEOUT = 0;
	localparam int IRQ_WAKEUP  = 1;
	// reset values
	localparam logic [7:0] BOOT_CFG_RST = 8'hFF;
	localparam logic [2:0] PS_RST       = 3'h7;
	localparam logic [1:0] IRQ_MASK_RST = 2'h0;
	// timing
	localparam int OSC_FREQ_HZ       = 10000;
	localparam int TIMEOUT_PERIODS   = 64;
	localparam int GRACE_OSC_CLOCKS  = 512;
	localparam int CLK_PERIOD_PS     = 5000;
	localparam int PS_DIV_MAX        = 256;
	// control states, gray along the usual path
	typedef enum logic [1:0] {
		WDTT_HALT  = 2'b00,
		WDTT_COUNT = 2'b01,
		WDTT_GRACE = 2'b11,
		WDTT_FIRE  = 2'b10
	} wdtt_state_type;
endpackage

/* File: logic/wdtt_prescale.sv */
// Purpose: selectable divider of slow oscillator ticks
// Assumes: tick_in is a one-cycle pulse per oscillator period
// Notes:   codes 0..7 divide by 1,4,8,16,32,64,128,256
`timescale 1ns/10ps
module wdtt_prescale
	import wdtt_pkg::*;
#(
	parameter int DIV_W = 8
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       tick_in,
	input  wire logic       clear,
	input  wire logic [2:0] sel,
	output logic            tick_out
);
	logic [DIV_W-1:0] cnt;
	logic [DIV_W-1:0] last;
	wire              wrap;

	// ratio minus one for the selected code
	assign last = (sel == 3'h0) ? '0 : DIV_W'((1 << (32'(sel) + 1)) - 1);
	assign wrap = (cnt >= last);

	// divider chain on oscillator ticks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt      <= '0;
			tick_out <= 1'b0;
		end else if (ce) begin
			tick_out <= 1'b0;
			if (clear) begin
				cnt <= '0;
			end else if (tick_in) begin
				cnt      <= wrap ? '0 : cnt + 1'b1;
				tick_out <= wrap;
			end
		end
	end
endmodule

/* File: logic/wdtt_sync.sv */
// Purpose: two flip-flop level synchroniser
// Assumes: input may change at any time relative to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module wdtt_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// two stages, frozen with the clock enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

/* File: logic/wdtt_top.sv */
// Purpose: watchdog timeout timer with register port and interrupt
// Assumes: slow_internal_osc is a free running level near 10 kHz
// Notes:   sys_rst_n resets all but reset cause, boot config, irq status and irq mask
// Behaviour
// - behaviour code 1111 disables reset; counter is a software timer
// - code 0101 gives reset timer halted in idle or power-down
// - any other code gives reset timer running in low power
// - counter clocked through divider fed by slow 10 kHz oscillator
// - software selects divider output, which sets the timeout interval
// - prescale codes 000..111 divide by 1,4,8,16,32,64,128,256
// - timeout after 64 divided oscillator periods
// - timeout wakes the system from idle or power-down
// - timeout raises interrupt only when its enable is set
// - reset timer resets the system unless serviced within the delay
// - watchdog reset resets the whole device
// - timer mode gives periodic interrupt, also in low power; here in low power only when wd_idle_run is set
// - behaviour field defaults to all ones, reset function off
// - grace delay is 512 oscillator clocks after a timeout
// - writing one clears counter; bit reads one until done
// - reset cause flag survives all but power-on; software clears it
// - run bit starts and halts timer mode; flag set each interval
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/10ps
module wdtt_top
	import wdtt_pkg::*;
#(
	parameter int CNT_W   = 6,
	parameter int GRACE_W = 10
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       ce,
	input  wire logic       sys_rst_n,
	input  wire logic       slow_internal_osc,
	input  wire logic       idle_mode,
	input  wire logic       powerdown_mode,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            irq,
	output logic            wakeup,
	output logic            wd_system_reset
);
	logic           rst_meta;
	logic           rst_n;
	logic           osc_s;
	logic           osc_d;
	logic           osc_tick;
	logic           div_tick;
	logic [7:0]     watchdog_boot_config;
	logic           wd_run_bit;
	logic           wd_idle_run;
	logic           wd_timeout_flag;
	logic           wd_reset_cause_flag;
	logic [2:0]     wd_prescale_select;
	logic           clear_pending;
	logic [1:0]     irq_status;
	logic [1:0]     irq_mask;
	logic [CNT_W-1:0]   count;
	logic [GRACE_W-1:0] grace;
	wdtt_state_type state;
	wdtt_state_type next_state;

	// reset release through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// oscillator level into clk domain
	wdtt_sync #(.W(1)) u_osc_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.d     (slow_internal_osc),
		.q     (osc_s)
	);

	// rising edge of synchronised oscillator
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_d <= 1'b0;
		end else if (ce) begin
			osc_d <= osc_s;
		end
	end
	assign osc_tick = osc_s & ~osc_d;

	// decoded behaviour and activity
	wire [3:0] wd_behaviour_select = watchdog_boot_config[BEH_LSB +: BEH_W];
	wire gp_mode    = (wd_behaviour_select == BEH_GP_TIMER);
	wire stop_lp    = (wd_behaviour_select == BEH_RST_STOP);
	wire low_power  = idle_mode | powerdown_mode;
	wire rst_active = ~gp_mode & ~(stop_lp & low_power);
	wire gp_active  = gp_mode & wd_run_bit & (~low_power | wd_idle_run);
	wire active     = rst_active | gp_active;
	wire soft_rst   = ~sys_rst_n | wd_system_reset;
	wire clr_apply  = clear_pending & osc_tick;

	wdtt_prescale #(.DIV_W(8)) u_prescale (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.tick_in  (osc_tick & active),
		.clear    (clr_apply | soft_rst),
		.sel      (wd_prescale_select),
		.tick_out (div_tick)
	);

	// register decode
	wire wr_ctrl  = reg_wr & (reg_addr == OFS_CTRL);
	wire wr_boot  = reg_wr & (reg_addr == OFS_BOOT_CFG);
	wire wr_istat = reg_wr & (reg_addr == OFS_IRQ_STAT);
	wire wr_imask = reg_wr & (reg_addr == OFS_IRQ_MASK);
	wire [7:0] ctrl_view = {wd_run_bit, clear_pending, wd_timeout_flag, wd_idle_run,
		wd_reset_cause_flag, wd_prescale_select};
	wire [7:0] rd_mux =
		(reg_addr == OFS_CTRL)     ? ctrl_view :
		(reg_addr == OFS_BOOT_CFG) ? watchdog_boot_config :
		(reg_addr == OFS_IRQ_STAT) ? {6'h00, irq_status} :
		(reg_addr == OFS_IRQ_MASK) ? {6'h00, irq_mask} :
		(reg_addr == OFS_COUNT)    ? 8'(count) : 8'h00;

	// counter and timeout event
	wire at_last    = (count == CNT_W'(TIMEOUT_PERIODS - 1));
	wire timeout_ev = div_tick & at_last & (state == WDTT_COUNT);
	wire grace_end  = osc_tick & (grace == GRACE_W'(GRACE_OSC_CLOCKS - 1));

	// control state machine
	always_comb begin
		next_state = state;
		case (state)
			WDTT_HALT: begin
				if (active) begin
					next_state = WDTT_COUNT;
				end
			end
			WDTT_COUNT: begin
				if (!active) begin
					next_state = WDTT_HALT;
				end else if (timeout_ev && !gp_mode) begin
					next_state = WDTT_GRACE;
				end
			end
			WDTT_GRACE: begin
				if (clr_apply) begin
					next_state = WDTT_COUNT;
				end else if (grace_end) begin
					next_state = WDTT_FIRE;
				end
			end
			WDTT_FIRE: begin
				next_state = WDTT_HALT;
			end
			default: begin
				next_state = WDTT_HALT;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= WDTT_HALT;
		end else if (ce) begin
			state <= soft_rst ? WDTT_HALT : next_state;
		end
	end

	// timeout counter and grace counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			grace <= '0;
		end else if (ce) begin
			if (soft_rst || clr_apply) begin
				count <= '0;
				grace <= '0;
			end else begin
				if (div_tick && state == WDTT_COUNT) begin
					count <= count + 1'b1;
				end
				if (state != WDTT_GRACE) begin
					grace <= '0;
				end else if (osc_tick) begin
					grace <= grace + 1'b1;
				end
			end
		end
	end

	// boot config and cause flag, power-on reset only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_boot_config <= BOOT_CFG_RST;
			wd_reset_cause_flag  <= 1'b0;
		end else if (ce) begin
			if (wr_boot) begin
				watchdog_boot_config <= reg_wdata;
			end
			wd_reset_cause_flag <= wd_system_reset |
				(wd_reset_cause_flag & ~(wr_ctrl & reg_wdata[BIT_CAUSE]));
		end
	end

	// control bits, cleared by system reset too
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_run_bit         <= 1'b0;
			wd_idle_run        <= 1'b0;
			wd_prescale_select <= PS_RST;
			wd_timeout_flag    <= 1'b0;
			clear_pending      <= 1'b0;
		end else if (ce) begin
			if (soft_rst) begin
				wd_run_bit         <= 1'b0;
				wd_idle_run        <= 1'b0;
				wd_prescale_select <= PS_RST;
				wd_timeout_flag    <= 1'b0;
				clear_pending      <= 1'b0;
			end else begin
				if (wr_ctrl) begin
					wd_run_bit         <= reg_wdata[BIT_RUN];
					wd_idle_run        <= reg_wdata[BIT_IDLE_RUN];
					wd_prescale_select <= reg_wdata[PS_LSB +: PS_W];
				end
				wd_timeout_flag <= timeout_ev |
					(wd_timeout_flag & ~(wr_ctrl & reg_wdata[BIT_TOFLAG]));
				clear_pending <= (wr_ctrl & reg_wdata[BIT_CLEAR]) |
					(clear_pending & ~osc_tick);
			end
		end
	end

	// interrupt status, mask, outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status      <= '0;
			irq_mask        <= IRQ_MASK_RST;
			irq             <= 1'b0;
			wakeup          <= 1'b0;
			wd_system_reset <= 1'b0;
			reg_rdata       <= 8'h00;
		end else if (ce) begin
			irq_status[IRQ_TIMEOUT] <= timeout_ev |
				(irq_status[IRQ_TIMEOUT] & ~(wr_istat & reg_wdata[IRQ_TIMEOUT]));
			irq_status[IRQ_WAKEUP] <= (timeout_ev & low_power) |
				(irq_status[IRQ_WAKEUP] & ~(wr_istat & reg_wdata[IRQ_WAKEUP]));
			if (wr_imask) begin
				irq_mask <= reg_wdata[1:0];
			end
			irq             <= |(irq_status & irq_mask);
			wakeup          <= timeout_ev & low_power;
			wd_system_reset <= (next_state == WDTT_FIRE) & ~soft_rst;
			reg_rdata       <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);

	sequence s_grace_expire;
		state == WDTT_GRACE && grace_end && !clr_apply && sys_rst_n;
	endsequence
	sequence s_clear_write;
		wr_ctrl && reg_wdata[BIT_CLEAR] && sys_rst_n && !wd_system_reset;
	endsequence

	a_grace_fires: assert property (s_grace_expire |=> wd_system_reset)
		else $error("no reset after grace expiry");
	a_cause_sets: assert property (wd_system_reset |=> wd_reset_cause_flag)
		else $error("cause flag not set by watchdog reset");
	a_gp_no_reset: assert property (gp_mode && state != WDTT_GRACE |=> !wd_system_reset)
		else $error("reset raised in timer mode");
	a_clear_pending: assert property (s_clear_write ##1 !osc_tick |-> clear_pending)
		else $error("clear bit not pending");
	a_halt_lowpwr: assert property (stop_lp && low_power && state == WDTT_HALT
		&& !soft_rst && !clr_apply |=> $stable(count))
		else $error("counter moved in low power");
	a_irq_masked: assert property (irq |-> $past(|(irq_status & irq_mask)))
		else $error("irq without enabled status");
	a_wake_cause: assert property (wakeup |-> $past(timeout_ev && low_power))
		else $error("wakeup without timeout");
	a_flag_sets: assert property (timeout_ev && !soft_rst |=> wd_timeout_flag)
		else $error("timeout flag not set");
	a_timeout_wrap: assert property (timeout_ev && !soft_rst |=> count == '0)
		else $error("counter did not wrap at 64");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	a_clear_done: assert property (clear_pending && osc_tick && !wr_ctrl
		|=> !clear_pending)
		else $error("clear bit still set after oscillator edge");
	a_grace_back: assert property (state == WDTT_GRACE && clr_apply && !soft_rst
		|=> state == WDTT_COUNT)
		else $error("service in grace did not resume counting");
	a_irq_level: assert property (|(irq_status & irq_mask) |=> irq)
		else $error("irq low with enabled status");
endmodule

/* File: verif/wdtt_tb_top.sv */
// Purpose: self-checking bench of the watchdog timeout timer
// Assumes: bench drives the slow oscillator at one period per 8 clk
// Notes:   assertions live in the design files, so no checker here
`timescale 1ns/10ps
module wdtt_tb_top
	import wdtt_pkg::*;
;
	logic       clk;
	logic       arst_n;
	logic       ce;
	logic       sys_rst_n;
	logic       osc;
	logic       idle_mode;
	logic       powerdown_mode;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       irq;
	logic       wakeup;
	logic       wd_system_reset;
	logic [2:0] dv;
	int         osc_ticks;
	int         rst_cnt;
	int         wake_cnt;
	int         err_count;
	int         n_tests;

	wdtt_top DUT (
		.clk               (clk),
		.arst_n            (arst_n),
		.ce                (ce),
		.sys_rst_n         (sys_rst_n),
		.slow_internal_osc (osc),
		.idle_mode         (idle_mode),
		.powerdown_mode    (powerdown_mode),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_wr            (reg_wr),
		.reg_rd            (reg_rd),
		.reg_rdata         (reg_rdata),
		.irq               (irq),
		.wakeup            (wakeup),
		.wd_system_reset   (wd_system_reset)
	);

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// slow oscillator and event counters
	always @(posedge clk) begin
		dv <= dv + 3'h1;
		osc <= dv[2];
		if (dv == 3'h3) osc_ticks <= osc_ticks + 1;
		if (wd_system_reset === 1'b1) rst_cnt <= rst_cnt + 1;
		if (wakeup === 1'b1) wake_cnt <= wake_cnt + 1;
	end

	task automatic end_of_test();
		if (err_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read, mask and compare
	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata & m, e);
	endtask

	task automatic ticks(input int n);
		int t0;
		t0 = osc_ticks;
		for (int i = 0; i < n * 8 + 16 && osc_ticks < t0 + n; i++) @(posedge clk);
	endtask

	// wait for irq or a reset pulse; returns the tick count at the event
	task automatic wait_ev(input int lim, output int n);
		int r0;
		int i;
		r0 = rst_cnt;
		for (i = 0; i < lim * 8; i++) begin
			@(posedge clk);
			#1;
			if (irq === 1'b1 || rst_cnt != r0) break;
		end
		n = osc_ticks;
		if (i == lim * 8) begin
			err_count++;
			end_of_test();
		end
	endtask

	function automatic logic [7:0] near(input int a, input int b);
		return {7'h00, (a >= b - 3 && a <= b + 3)};
	endfunction

	task automatic t_reset_values();
		rdc(OFS_CTRL, 8'hFF, 8'h07);
		rdc(OFS_BOOT_CFG, 8'hFF, 8'hFF);
		rdc(OFS_IRQ_STAT, 8'hFF, 8'h00);
		rdc(OFS_IRQ_MASK, 8'hFF, 8'h00);
		rdc(8'h10, 8'hFF, 8'h00);
		rdc(OFS_COUNT, 8'hFF, 8'h00);
	endtask

	// clear bit reads one until an oscillator edge applies it
	task automatic t_clear_bit();
		// align to a fixed oscillator phase without touching the divider
		for (int i = 0; i < 9; i++) begin
			@(posedge clk);
			if (dv == 3'h3) break;
		end
		wr(OFS_CTRL, 8'h40);
		rdc(OFS_CTRL, 8'h40, 8'h40);
		ticks(2);
		rdc(OFS_CTRL, 8'h40, 8'h00);
	endtask

	task automatic t_prescale();
		int r[4] = '{1, 4, 8, 16};
		int t0;
		int n;
		wr(OFS_IRQ_MASK, 8'h01);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CTRL, 8'h40 | c[7:0]);
			ticks(2);
			wr(OFS_CTRL, 8'h80 | c[7:0]);
			t0 = osc_ticks;
			wait_ev(64 * r[c] + 40, n);
			check(near(n - t0, 64 * r[c]), 8'h01);
			rdc(OFS_CTRL, 8'h20, 8'h20);
			wr(OFS_CTRL, 8'h20);
			wr(OFS_IRQ_STAT, 8'h01);
			rdc(OFS_IRQ_STAT, 8'h01, 8'h00);
			check({7'h00, irq}, 8'h00);
		end
	endtask

	task automatic t_no_count();
		int t0;
		int n;
		wr(OFS_CTRL, 8'h40);
		ticks(80);
		rdc(OFS_IRQ_STAT, 8'h01, 8'h00);
		wr(OFS_IRQ_MASK, 8'h00);
		wr(OFS_CTRL, 8'h80);
		ticks(70);
		check({7'h00, irq}, 8'h00);
		rdc(OFS_IRQ_STAT, 8'h01, 8'h01);
		wr(OFS_CTRL, 8'h20);
		wr(OFS_IRQ_STAT, 8'h03);
		// timer mode in idle: halted unless the low-power run bit is set
		idle_mode <= 1'b1;
		wr(OFS_CTRL, 8'h80);
		ticks(70);
		rdc(OFS_IRQ_STAT, 8'h01, 8'h00);
		wr(OFS_IRQ_MASK, 8'h01);
		wr(OFS_CTRL, 8'hD0);
		t0 = osc_ticks;
		wait_ev(100, n);
		check(near(n - t0, 64), 8'h01);
		rdc(OFS_IRQ_STAT, 8'h03, 8'h03);
		idle_mode <= 1'b0;
		wr(OFS_CTRL, 8'h20);
		wr(OFS_IRQ_STAT, 8'h03);
	endtask

	// behaviour 0101 halts in power-down
	task automatic t_halt_lowpower();
		int t0;
		int n;
		wr(OFS_BOOT_CFG, 8'h50);
		wr(OFS_IRQ_MASK, 8'h01);
		powerdown_mode <= 1'b1;
		wr(OFS_CTRL, 8'h40);
		ticks(80);
		check({7'h00, irq}, 8'h00);
		powerdown_mode <= 1'b0;
		t0 = osc_ticks;
		wait_ev(100, n);
		check(near(n - t0, 64), 8'h01);
		wr(OFS_CTRL, 8'h60);
		wr(OFS_IRQ_STAT, 8'h03);
	endtask

	// other behaviour codes run in idle, wake and reset after the grace delay
	task automatic t_grace_reset();
		int n1;
		int n2;
		int w0;
		w0 = wake_cnt;
		wr(OFS_BOOT_CFG, 8'h00);
		idle_mode <= 1'b1;
		wr(OFS_IRQ_MASK, 8'h03);
		wr(OFS_CTRL, 8'h40);
		wait_ev(100, n1);
		check(8'(wake_cnt - w0), 8'h01);
		rdc(OFS_IRQ_STAT, 8'h03, 8'h03);
		wr(OFS_IRQ_STAT, 8'h03);
		wait_ev(560, n2);
		check(near(n2 - n1, 512), 8'h01);
		idle_mode <= 1'b0;
		rdc(OFS_CTRL, 8'h2F, 8'h0F);
		@(posedge clk);
		sys_rst_n <= 1'b0;
		@(posedge clk);
		sys_rst_n <= 1'b1;
		rdc(OFS_CTRL, 8'h08, 8'h08);
		wr(OFS_CTRL, 8'h08);
		rdc(OFS_CTRL, 8'h08, 8'h00);
	endtask

	// service inside the grace delay avoids the reset
	task automatic t_service();
		int n;
		int r0;
		wr(OFS_IRQ_STAT, 8'h03);
		wr(OFS_CTRL, 8'h40);
		wait_ev(100, n);
		r0 = rst_cnt;
		ticks(400);
		wr(OFS_CTRL, 8'h40);
		ticks(300);
		check(8'(rst_cnt - r0), 8'h00);
	endtask

	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		ce = 1'b1;
		sys_rst_n = 1'b1;
		osc = 1'b0;
		dv = 3'h0;
		idle_mode = 1'b0;
		powerdown_mode = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		osc_ticks = 0;
		rst_cnt = 0;
		wake_cnt = 0;
		err_count = 0;
		n_tests = 0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset_values();
		t_clear_bit();
		t_prescale();
		t_no_count();
		t_halt_lowpower();
		t_grace_reset();
		t_service();
		end_of_test();
	end
endmodule
